// ==== pbc_pkg.sv ====
// Shared constants and types for the page block check engine
package pbc_pkg;
    // Leaf selector and page geometry
    localparam logic [31:0] PBC_LEAF_BLOCK = 32'h0000_0009;
    localparam int PBC_PAGE_SHIFT = 12;
    localparam int PBC_PAGES_DEF = 16;
    localparam logic [1:0] PBC_CPL_KERNEL = 2'h0;
    // Register byte offsets
    localparam logic [7:0] PBC_OFS_ACC = 8'h00;
    localparam logic [7:0] PBC_OFS_ADDR_LO = 8'h04;
    localparam logic [7:0] PBC_OFS_ADDR_HI = 8'h08;
    localparam logic [7:0] PBC_OFS_CTRL = 8'h0C;
    localparam logic [7:0] PBC_OFS_DS_BASE = 8'h10;
    localparam logic [7:0] PBC_OFS_DS_LIMIT = 8'h14;
    localparam logic [7:0] PBC_OFS_CACHE_BASE = 8'h18;
    localparam logic [7:0] PBC_OFS_STATUS = 8'h1C;
    localparam logic [7:0] PBC_OFS_FAULT_LO = 8'h20;
    localparam logic [7:0] PBC_OFS_FAULT_HI = 8'h24;
    localparam logic [7:0] PBC_OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] PBC_OFS_IRQ_MASK = 8'h2C;
    localparam logic [7:0] PBC_OFS_META_SEL = 8'h30;
    localparam logic [7:0] PBC_OFS_META_DATA = 8'h34;
    // Field positions
    localparam int PBC_CTRL_GO = 0;
    localparam int PBC_CTRL_CPL = 1;
    localparam int PBC_CTRL_LONG = 3;
    localparam int PBC_ST_BUSY = 0;
    localparam int PBC_ST_FLAGS = 1;
    localparam int PBC_ST_GP = 8;
    localparam int PBC_ST_PF = 9;
    localparam int PBC_IRQ_DONE = 0;
    localparam int PBC_IRQ_GP = 1;
    localparam int PBC_IRQ_PF = 2;
    localparam int PBC_IRQ_W = 3;
    // Reset values
    localparam logic [31:0] PBC_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] PBC_RST_LIMIT = 32'hFFFF_FFFF;
    // Page type encodings
    localparam logic [2:0] PBC_PT_REGULAR = 3'h0;
    localparam logic [2:0] PBC_PT_THREAD = 3'h1;
    localparam logic [2:0] PBC_TRIMMED_PAGE_TYPE = 3'h2;
    localparam logic [2:0] PBC_SHADOW_STACK_FIRST_TYPE = 3'h3;
    localparam logic [2:0] PBC_SHADOW_STACK_REST_TYPE = 3'h4;
    localparam logic [2:0] PBC_PT_CONTROL = 3'h5;
    // Default status codes, all distinct
    localparam logic [31:0] PBC_CODE_NOERR = 32'h0000_0000;
    localparam logic [31:0] PBC_CODE_ALREADY = 32'h0000_0001;
    localparam logic [31:0] PBC_CODE_EPOCH = 32'h0000_0002;
    localparam logic [31:0] PBC_CODE_UNBLK = 32'h0000_0003;
    localparam logic [31:0] PBC_CODE_INVALID = 32'h0000_0004;
    localparam logic [31:0] PBC_CODE_CONFLICT = 32'h0000_0005;
    localparam logic [31:0] PBC_CODE_CTRL = 32'h0000_0006;
    // One page cache metadata entry
    typedef struct packed {
        logic epoch_lock;
        logic res_lock;
        logic in_write;
        logic blocked;
        logic valid;
        logic [2:0] ptype;
    } pbc_meta_s;
    // Arithmetic flags, zero flag lowest
    typedef struct packed {
        logic sf;
        logic of;
        logic af;
        logic pf;
        logic carry_flag;
        logic zero_flag;
    } pbc_flags_s;
    typedef enum logic [1:0] {
        PBC_IDLE = 2'b01,
        PBC_EXEC = 2'b10
    } pbc_state_e;
endpackage : pbc_pkg

// ==== pbc_addr_check.sv ====
// Address formation and page cache lookup for the block leaf
`timescale 1ns/1ps
`default_nettype none
module pbc_addr_check import pbc_pkg::*; #(
    parameter int PAGES = PBC_PAGES_DEF,
    parameter int IDX_W = $clog2(PAGES)
) (
    input wire logic [63:0] ea, // Effective page address
    input wire logic long_mode, // 64-bit mode
    input wire logic [31:0] ds_base, // Data segment base
    input wire logic [31:0] ds_limit, // Data segment limit
    input wire logic [31:0] cache_base, // Page cache base
    output logic gp_limit, // Beyond segment limit
    output logic gp_canon, // Non-canonical address
    output logic gp_align, // Not page aligned
    output logic in_cache, // Resolves inside cache
    output logic [IDX_W-1:0] page_idx // Entry index
);
    logic [63:0] lin;
    logic [31:0] off;
    // Data segment always forms the linear address
    always_comb begin
        if (long_mode) begin
            lin = ea + {32'h0000_0000, ds_base};
        end else begin
            lin = {32'h0000_0000, ea[31:0] + ds_base};
        end
        off = lin[31:0] - cache_base;
    end
    // Fault conditions; limit only matters outside 64-bit mode
    always_comb begin
        gp_limit = !long_mode && (ea[31:0] > ds_limit);
        gp_canon = long_mode && !((&ea[63:47]) || !(|ea[63:47]));
        gp_align = |lin[PBC_PAGE_SHIFT-1:0];
        in_cache = (lin[63:32] == 32'h0000_0000) && (lin[31:0] >= cache_base)
            && (off[31:PBC_PAGE_SHIFT] < 20'(PAGES));
        page_idx = off[PBC_PAGE_SHIFT +: IDX_W];
    end
endmodule : pbc_addr_check
`default_nettype wire

// ==== pbc_block_engine.sv ====
// Page block leaf engine with AHB-Lite register slave
// How it works
// - Leaf code 09H in the accumulator selects page blocking.
// - Only privilege level 0 may run it; others fault.
// - Linear address is operand plus data segment base, no override.
// - Unaligned page address gives protection fault, code zero, no change.
// - Address outside the page cache gives page fault with address.
// - After address checks, clear six flags and zero the accumulator.
// - Page being written: set zero flag, return conflict code.
// - Invalid page: set zero flag, return invalid code.
// - Unblockable type sets carry; control page gets its own code.
// - Already blocked page sets carry, returns already-blocked code.
// - Blockable page epoch-locked returns epoch code; software retries.
// - Otherwise mark blocked, flags clear, no-error code returned.
// - Shared access; conflicts report a status code, not a fault.
// - Segment limit or non-canonical address gives fault code zero.
// - Protected resource in use gives protection fault code zero.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pbc_block_engine import pbc_pkg::*; #(
    parameter int PAGES = PBC_PAGES_DEF,
    parameter logic [31:0] CODE_NOERR = PBC_CODE_NOERR,
    parameter logic [31:0] CODE_ALREADY = PBC_CODE_ALREADY,
    parameter logic [31:0] CODE_EPOCH = PBC_CODE_EPOCH,
    parameter logic [31:0] CODE_UNBLK = PBC_CODE_UNBLK,
    parameter logic [31:0] CODE_INVALID = PBC_CODE_INVALID,
    parameter logic [31:0] CODE_CONFLICT = PBC_CODE_CONFLICT,
    parameter logic [31:0] CODE_CTRL = PBC_CODE_CTRL
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, high
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data
    output logic irq, // Unmasked event level
    output logic op_done, // Leaf finished pulse
    output logic gp_fault, // Protection fault pulse
    output logic pf_fault // Page fault pulse
);
    localparam int IDX_W = $clog2(PAGES);
    pbc_state_e state, next_state;
    logic [31:0] acc, next_acc;
    logic [63:0] ea, next_ea;
    logic [1:0] cpl, next_cpl;
    logic long_mode, next_long_mode;
    logic [31:0] ds_base, next_ds_base, ds_limit, next_ds_limit;
    logic [31:0] cache_base, next_cache_base;
    pbc_flags_s flags, next_flags;
    logic last_gp, next_last_gp, last_pf, next_last_pf;
    logic [63:0] fault_addr, next_fault_addr;
    logic [PBC_IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
    logic [IDX_W-1:0] meta_sel, next_meta_sel;
    pbc_meta_s meta [PAGES], next_meta [PAGES];
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic next_hreadyout, next_hresp, next_irq;
    logic next_op_done, next_gp_fault, next_pf_fault;
    logic gp_limit, gp_canon, gp_align, in_cache;
    logic [IDX_W-1:0] page_idx;
    logic addr_take, go, exec;
    logic leaf_ok, priv_ok, gp_early, pf_hit, gp_lock, any_fault;
    logic blockable, block_now, pending;
    pbc_meta_s sel;
    logic [PBC_IRQ_W-1:0] w1c, ev;
    pbc_addr_check #(
        .PAGES(PAGES),
        .IDX_W(IDX_W)
    ) u_addr (
        .ea(ea),
        .long_mode(long_mode),
        .ds_base(ds_base),
        .ds_limit(ds_limit),
        .cache_base(cache_base),
        .gp_limit(gp_limit),
        .gp_canon(gp_canon),
        .gp_align(gp_align),
        .in_cache(in_cache),
        .page_idx(page_idx)
    );
    // Register read mux; unmapped offsets read zero
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] w;
        w = PBC_RST_WORD;
        case (a)
            PBC_OFS_ACC: w = acc;
            PBC_OFS_ADDR_LO: w = ea[31:0];
            PBC_OFS_ADDR_HI: w = ea[63:32];
            PBC_OFS_CTRL: begin
                w[PBC_CTRL_CPL +: 2] = cpl;
                w[PBC_CTRL_LONG] = long_mode;
            end
            PBC_OFS_DS_BASE: w = ds_base;
            PBC_OFS_DS_LIMIT: w = ds_limit;
            PBC_OFS_CACHE_BASE: w = cache_base;
            PBC_OFS_STATUS: begin
                w[PBC_ST_BUSY] = (state == PBC_EXEC);
                w[PBC_ST_FLAGS +: 6] = flags;
                w[PBC_ST_GP] = last_gp;
                w[PBC_ST_PF] = last_pf;
            end
            PBC_OFS_FAULT_LO: w = fault_addr[31:0];
            PBC_OFS_FAULT_HI: w = fault_addr[63:32];
            PBC_OFS_IRQ_STAT: w[PBC_IRQ_W-1:0] = irq_stat;
            PBC_OFS_IRQ_MASK: w[PBC_IRQ_W-1:0] = irq_mask;
            PBC_OFS_META_SEL: w[IDX_W-1:0] = meta_sel;
            PBC_OFS_META_DATA: w[7:0] = meta[meta_sel];
            default: w = PBC_RST_WORD;
        endcase
        return w;
    endfunction : rd_word
    // Bus slave: never stalls, so read data is fetched in address phase
    always_comb begin
        addr_take = hsel && hready && htrans[1];
        next_wr_pend = addr_take && hwrite;
        next_wr_addr = addr_take ? haddr[7:0] : wr_addr;
        next_hrdata = hrdata;
        if (addr_take && !hwrite) begin
            next_hrdata = rd_word(haddr[7:0]);
        end
        next_hreadyout = 1'b1;
        next_hresp = 1'b0;
        pending = |(irq_stat & irq_mask);
        next_irq = pending;
    end
    // Check chain; earlier faults mask every later check
    always_comb begin
        exec = (state == PBC_EXEC);
        sel = in_cache ? meta[page_idx] : pbc_meta_s'(8'h00);
        leaf_ok = (acc == PBC_LEAF_BLOCK);
        priv_ok = (cpl == PBC_CPL_KERNEL);
        gp_early = !leaf_ok || !priv_ok || gp_limit || gp_canon
            || gp_align;
        pf_hit = !gp_early && !in_cache;
        gp_lock = !gp_early && in_cache && sel.res_lock;
        any_fault = gp_early || pf_hit || gp_lock;
        blockable = (sel.ptype == PBC_PT_REGULAR)
            || (sel.ptype == PBC_PT_THREAD)
            || (sel.ptype == PBC_TRIMMED_PAGE_TYPE)
            || (sel.ptype == PBC_SHADOW_STACK_FIRST_TYPE)
            || (sel.ptype == PBC_SHADOW_STACK_REST_TYPE);
        block_now = exec && !any_fault && !sel.in_write && sel.valid
            && blockable && !sel.blocked && !sel.epoch_lock;
    end
    // Software writes, engine results, interrupt status
    always_comb begin
        next_state = state;
        next_acc = acc;
        next_ea = ea;
        next_cpl = cpl;
        next_long_mode = long_mode;
        next_ds_base = ds_base;
        next_ds_limit = ds_limit;
        next_cache_base = cache_base;
        next_flags = flags;
        next_last_gp = last_gp;
        next_last_pf = last_pf;
        next_fault_addr = fault_addr;
        next_irq_mask = irq_mask;
        next_meta_sel = meta_sel;
        next_meta = meta;
        next_op_done = 1'b0;
        next_gp_fault = 1'b0;
        next_pf_fault = 1'b0;
        go = 1'b0;
        w1c = '0;
        ev = '0;
        if (wr_pend) begin
            case (wr_addr)
                PBC_OFS_ACC: next_acc = hwdata;
                PBC_OFS_ADDR_LO: next_ea[31:0] = hwdata;
                PBC_OFS_ADDR_HI: next_ea[63:32] = hwdata;
                PBC_OFS_CTRL: begin
                    go = hwdata[PBC_CTRL_GO];
                    next_cpl = hwdata[PBC_CTRL_CPL +: 2];
                    next_long_mode = hwdata[PBC_CTRL_LONG];
                end
                PBC_OFS_DS_BASE: next_ds_base = hwdata;
                PBC_OFS_DS_LIMIT: next_ds_limit = hwdata;
                PBC_OFS_CACHE_BASE: next_cache_base = hwdata;
                PBC_OFS_IRQ_STAT: w1c = hwdata[PBC_IRQ_W-1:0];
                PBC_OFS_IRQ_MASK: next_irq_mask = hwdata[PBC_IRQ_W-1:0];
                PBC_OFS_META_SEL: next_meta_sel = hwdata[IDX_W-1:0];
                PBC_OFS_META_DATA: next_meta[meta_sel] = hwdata[7:0];
                default: go = 1'b0;
            endcase
        end
        unique case (state)
            PBC_IDLE: begin
                // A start while busy is ignored; one check cycle only
                if (go) begin
                    next_state = PBC_EXEC;
                end
            end
            PBC_EXEC: begin
                next_state = PBC_IDLE;
                next_op_done = 1'b1;
                ev[PBC_IRQ_DONE] = 1'b1;
                next_last_gp = gp_early || gp_lock;
                next_last_pf = pf_hit;
                if (gp_early || gp_lock) begin
                    // Faults leave accumulator, flags and metadata as is
                    next_gp_fault = 1'b1;
                    ev[PBC_IRQ_GP] = 1'b1;
                end else if (pf_hit) begin
                    next_pf_fault = 1'b1;
                    next_fault_addr = ea;
                    ev[PBC_IRQ_PF] = 1'b1;
                end else begin
                    next_flags = '0;
                    next_acc = CODE_NOERR;
                    // Writers only give a status code, never a fault
                    if (sel.in_write) begin
                        next_flags.zero_flag = 1'b1;
                        next_acc = CODE_CONFLICT;
                    end else if (!sel.valid) begin
                        next_flags.zero_flag = 1'b1;
                        next_acc = CODE_INVALID;
                    end else if (!blockable) begin
                        next_flags.carry_flag = 1'b1;
                        next_acc = (sel.ptype == PBC_PT_CONTROL)
                            ? CODE_CTRL : CODE_UNBLK;
                    end else if (sel.blocked) begin
                        next_flags.carry_flag = 1'b1;
                        next_acc = CODE_ALREADY;
                    end else if (sel.epoch_lock) begin
                        next_acc = CODE_EPOCH;
                    end
                end
            end
        endcase
        // Engine update wins over a software write to the same entry
        if (block_now) begin
            next_meta[page_idx].blocked = 1'b1;
        end
        // Set wins over a clear in the same cycle
        next_irq_stat = (irq_stat & ~w1c) | ev;
    end
    // Engine and bus state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= PBC_IDLE;
            acc <= PBC_RST_WORD;
            ea <= 64'h0000_0000_0000_0000;
            cpl <= PBC_CPL_KERNEL;
            long_mode <= 1'b0;
            ds_base <= PBC_RST_WORD;
            ds_limit <= PBC_RST_LIMIT;
            cache_base <= PBC_RST_WORD;
            flags <= '0;
            last_gp <= 1'b0;
            last_pf <= 1'b0;
            fault_addr <= 64'h0000_0000_0000_0000;
            irq_stat <= '0;
            irq_mask <= '0;
            meta_sel <= '0;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= PBC_RST_WORD;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= 1'b0;
            op_done <= 1'b0;
            gp_fault <= 1'b0;
            pf_fault <= 1'b0;
        end else begin
            state <= next_state;
            acc <= next_acc;
            ea <= next_ea;
            cpl <= next_cpl;
            long_mode <= next_long_mode;
            ds_base <= next_ds_base;
            ds_limit <= next_ds_limit;
            cache_base <= next_cache_base;
            flags <= next_flags;
            last_gp <= next_last_gp;
            last_pf <= next_last_pf;
            fault_addr <= next_fault_addr;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            meta_sel <= next_meta_sel;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp <= next_hresp;
            irq <= next_irq;
            op_done <= next_op_done;
            gp_fault <= next_gp_fault;
            pf_fault <= next_pf_fault;
        end
    end
    // Metadata entries, one register each
    for (genvar i = 0; i < PAGES; i++) begin : g_meta
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                meta[i] <= '0;
            end else begin
                meta[i] <= next_meta[i];
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_leaf_select: assert property (
        exec && !leaf_ok |=> gp_fault && !pf_fault && $stable(acc))
        else $error("wrong leaf code did not fault");
    chk_priv_level: assert property (
        exec && !priv_ok |=> gp_fault && last_gp && $stable(flags))
        else $error("nonzero privilege not rejected");
    chk_align_fault: assert property (
        exec && leaf_ok && priv_ok && gp_align
        |=> gp_fault && $stable(acc) && $stable(flags))
        else $error("unaligned page did not fault cleanly");
    chk_page_fault: assert property (
        exec && pf_hit |=> pf_fault && fault_addr == $past(ea)
        && !gp_fault)
        else $error("page fault missing or wrong address");
    chk_flags_clear: assert property (
        exec && !any_fault |=> !flags.pf && !flags.af && !flags.of
        && !flags.sf)
        else $error("flags not cleared after checks");
    chk_conflict_code: assert property (
        exec && !any_fault && sel.in_write
        |=> flags.zero_flag && acc == CODE_CONFLICT && !gp_fault)
        else $error("conflict code wrong");
    chk_invalid_page: assert property (
        exec && !any_fault && !sel.in_write && !sel.valid
        |=> flags.zero_flag && !flags.carry_flag && acc == CODE_INVALID)
        else $error("invalid page code wrong");
    chk_type_reject: assert property (
        exec && !any_fault && !sel.in_write && sel.valid && !blockable
        |=> flags.carry_flag && !flags.zero_flag
        && acc == ($past(sel.ptype) == PBC_PT_CONTROL
        ? CODE_CTRL : CODE_UNBLK))
        else $error("unblockable type handled wrong");
    chk_already_blk: assert property (
        exec && !any_fault && !sel.in_write && sel.valid && blockable
        && sel.blocked |=> flags.carry_flag && acc == CODE_ALREADY)
        else $error("already blocked code wrong");
    chk_epoch_lock: assert property (
        exec && !any_fault && !sel.in_write && sel.valid && blockable
        && !sel.blocked && sel.epoch_lock
        |=> acc == CODE_EPOCH && !meta[$past(page_idx)].blocked)
        else $error("epoch lock not reported");
    chk_block_done: assert property (
        block_now |=> acc == CODE_NOERR && !flags.zero_flag
        && !flags.carry_flag && meta[$past(page_idx)].blocked)
        else $error("page not blocked on success");
    chk_lock_fault: assert property (
        exec && gp_lock |=> gp_fault ##1 !gp_fault && state == PBC_IDLE)
        else $error("resource lock did not fault");
    chk_irq_level: assert property (
        ##1 irq == $past(pending))
        else $error("irq level does not follow status");
endmodule : pbc_block_engine
`default_nettype wire

// ==== pbc_sw_model.sv ====
// Software side model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module pbc_sw_model (
    input wire logic clk, // Core clock
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    output logic hsel, // Slave select
    output logic [31:0] haddr, // Byte address
    output logic [1:0] htrans, // Transfer type
    output logic hwrite, // Write
    output logic [2:0] hsize, // Word size
    output logic [31:0] hwdata // Write data
);
    // Bus idle from time zero
    initial begin
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // One word write; data line flipped once released
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h00, a};
        hwrite <= 1'b1;
        htrans <= 2'h2;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hwdata <= ~d; // Stale data would hide a late sample
    endtask : wr

    // One word read, data taken at the data phase edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        haddr <= {24'h00, a};
        hwrite <= 1'b0;
        htrans <= 2'h2;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        d = hrdata;
    endtask : rd
endmodule : pbc_sw_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the page block engine
`timescale 1ns/1ps
`default_nettype none
module tb import pbc_pkg::*; ;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, irq;
    logic op_done, gp_fault, pf_fault;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize, msk;
    int failures = 0;
    int total_checks = 0;
    localparam logic [31:0] B = 32'h0010_0000; // Page cache base
    localparam logic [31:0] LF = PBC_LEAF_BLOCK;

    pbc_sw_model pbc_sw_model_i (.clk(clk), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    pbc_block_engine pbc_block_engine_i (.clk(clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq(irq), .op_done(op_done), .gp_fault(gp_fault),
        .pf_fault(pf_fault));

    // Free running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Read a register and compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        pbc_sw_model_i.rd(a, rv);
        check(rv, exp);
    endtask : rdc

    // Load metadata and operands, run, check result and events
    task automatic tcase(input logic [7:0] e, m, input logic [31:0] lf,
            lo, hi, input logic [3:0] ct, input logic [31:0] ea, es);
        pbc_sw_model_i.wr(PBC_OFS_META_SEL, {24'h00, e});
        pbc_sw_model_i.wr(PBC_OFS_META_DATA, {24'h00, m});
        pbc_sw_model_i.wr(PBC_OFS_ACC, lf);
        pbc_sw_model_i.wr(PBC_OFS_ADDR_LO, lo);
        pbc_sw_model_i.wr(PBC_OFS_ADDR_HI, hi);
        pbc_sw_model_i.wr(PBC_OFS_CTRL, {28'h0, ct});
        // Pulses stand for the one cycle after the check cycle only
        @(posedge clk);
        #1;
        check({28'h0, hresp, op_done, gp_fault, pf_fault},
            {30'h1, es[8], es[9]});
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, irq}, {31'h0, msk != 3'h0});
        @(posedge clk);
        rdc(PBC_OFS_ACC, ea);
        pbc_sw_model_i.rd(PBC_OFS_STATUS, rv);
        check(rv & 32'h0000_037F, es);
        rdc(PBC_OFS_IRQ_STAT, {29'h0, es[9], es[8], 1'b1});
        pbc_sw_model_i.wr(PBC_OFS_IRQ_STAT, 32'h0000_0007);
        rdc(PBC_OFS_IRQ_STAT, 32'h0000_0000);
        $display("test done: entry %0d result %h", e, ea);
    endtask : tcase

    // Verdict and end of run
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // Watchdog, far beyond the expected run of well under a thousand cycles
    initial begin
        #100000;
        failures++;
        results();
    end

    // Main sequence; faults first so flags are still clear
    initial begin
        rst = 1'b1;
        msk = 3'h7;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(PBC_OFS_DS_LIMIT, PBC_RST_LIMIT);
        rdc(8'h3C, 32'h0000_0000);
        pbc_sw_model_i.wr(PBC_OFS_CACHE_BASE, B);
        pbc_sw_model_i.wr(PBC_OFS_IRQ_MASK, 32'h0000_0007);
        tcase(0, 8'h08, 32'h0A, B, 0, 4'h1, 32'h0A, 32'h100);
        tcase(0, 8'h08, LF, B, 0, 4'h3, LF, 32'h100);
        tcase(0, 8'h08, LF, B + 4, 0, 4'h1, LF, 32'h100);
        tcase(0, 8'h08, LF, B + 32'h10000, 0, 4'h1, LF, 32'h200);
        rdc(PBC_OFS_FAULT_LO, B + 32'h10000);
        rdc(PBC_OFS_FAULT_HI, 32'h0000_0000);
        tcase(0, 8'h08, LF, B, 32'h8000, 4'h9, LF, 32'h100);
        tcase(6, 8'h48, LF, B + 32'h6000, 0, 4'h1, LF, 32'h100);
        pbc_sw_model_i.wr(PBC_OFS_DS_LIMIT, B);
        tcase(1, 8'h08, LF, B + 32'h1000, 0, 4'h1, LF, 32'h100);
        pbc_sw_model_i.wr(PBC_OFS_DS_LIMIT, PBC_RST_LIMIT);
        tcase(1, 8'h28, LF, B + 32'h1000, 0, 4'h1, PBC_CODE_CONFLICT,
            32'h2);
        tcase(2, 8'h00, LF, B + 32'h2000, 0, 4'h1, PBC_CODE_INVALID,
            32'h2);
        tcase(3, 8'h0D, LF, B + 32'h3000, 0, 4'h1, PBC_CODE_CTRL,
            32'h4);
        tcase(4, 8'h0E, LF, B + 32'h4000, 0, 4'h1, PBC_CODE_UNBLK,
            32'h4);
        tcase(0, 8'h08, LF, B, 0, 4'h1, PBC_CODE_NOERR, 32'h0);
        rdc(PBC_OFS_META_DATA, 32'h18);
        tcase(0, 8'h18, LF, B, 0, 4'h1, PBC_CODE_ALREADY, 32'h4);
        tcase(5, 8'h88, LF, B + 32'h5000, 0, 4'h1, PBC_CODE_EPOCH,
            32'h0);
        rdc(PBC_OFS_META_DATA, 32'h88);
        tcase(5, 8'h08, LF, B + 32'h5000, 0, 4'h1, PBC_CODE_NOERR,
            32'h0);
        // Segment base moves every later address by one page
        pbc_sw_model_i.wr(PBC_OFS_DS_BASE, 32'h0000_1000);
        for (int t = 1; t < 5; t++) begin
            tcase(8'(6 + t), {5'h01, 3'(t)}, LF, B + (32'(5 + t) << 12),
                0, 4'h1, PBC_CODE_NOERR, 32'h0);
        end
        // Masked events must keep the line low
        msk = 3'h0;
        pbc_sw_model_i.wr(PBC_OFS_IRQ_MASK, 32'h0000_0000);
        tcase(11, 8'h08, LF, B + 32'hA000, 0, 4'h1, PBC_CODE_NOERR,
            0);
        results();
    end
endmodule : tb
`default_nettype wire
